// ===== acl_action_decoder.sv
// Action decoder for the second ACL lookup, with APB control registers
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - One 196-bit action format serves every rule of the lookup.
// - Fields are packed upward from bit 0 in the documented order.
// - Inner flag marks the action as belonging to the inner switch stage.
// - Stage force applies the forced code; code none sets stage action none.
// - Forced stage code is 5 bits: 0 none, 1-15 stages, 16 done.
// - Single copy arm copies next hit to host; copy enable copies all.
// - A hit with interrupt enable set raises an interrupt event.
// - Host copy enable copies the frame to the selected host queue.
// - The 3-bit queue select names the queue of every host copy.
// - Extract disable cancels earlier host extraction, then copy applies.
// - Learn block prevents source address learning for the frame.
// - Route block prevents layer-3 routing of the frame.
// - Policer enable polices with the policer chosen by the select field.
// - Without policer enable, the select field picks a source IP swap entry.
// - Override termination applies the action on already terminated frames.
// - Bucket index is base from service index table plus offset.
// - Rewrite bit 5 on multicast Delay_Resp: interval from offset and swap.
// - Route mode 3:2 of 1 and field A 8:7 of 3: offset gives bits 2:0.
// - Interval code with swap enable encodes interval 0..7 or -8..-1.
// - Mode 0 ORs dest, 1 ANDs VLAN mask, 2 replaces port group mask.
// - Mode 3 makes the port set the final, locked destination set.
// - Mode 4 redirects by port set bits 10:0, result locked.
// - Mode 5 ORs the port set into the port group mask.
// - Mode 6 controls stacking forwarding and locks; mode 7 no effect.
// - Host port membership is never changed by any mask mode.
// - Mode 4 bits 52, 51, 50 AND source, aggregation, VLAN masks.
module acl_action_decoder
	import acl_action_pkg::*;
#(
	parameter int HOST_PORT = 53,
	parameter int RULE_COUNT = 32
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frameValid,
	input wire logic ruleHit,
	input wire action_s action,
	input wire frame_s frameIn,
	output logic decisionValid,
	output decision_s decision,
	output logic hitEvent
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (HOST_PORT < 0 || HOST_PORT >= MASK_W) begin : gBadHost
		$error("HOST_PORT outside the port mask");
	end
	if (RULE_COUNT < 1 || RULE_COUNT > 32) begin : gBadRules
		$error("RULE_COUNT must be 1 to 32");
	end

	// ************************************************************
	// State and helpers
	// ************************************************************
	typedef struct packed {
		decision_s dec;
		logic outValid;
		logic hitEvent;
		logic [RULE_COUNT-1:0] consumed;
		logic [31:0] hitCount;
		logic decodeEnable;
		logic [31:0] rdata;
		logic slvErr;
	} state_s;

	state_s r;
	state_s rNxt;

	// Register decode: 0 ctrl, 1 arm, 2 hits, 3 unmapped
	function automatic logic [1:0] regDecode(input logic [7:0] addr);
		case (addr)
			REG_CTRL: regDecode = 2'h0;
			REG_ARM: regDecode = 2'h1;
			REG_HITS: regDecode = 2'h2;
			default: regDecode = 2'h3;
		endcase
	endfunction

	logic [54:0] hostBit;
	logic [54:0] newMask;
	logic [54:0] andTerm;
	logic applies;
	logic armedCopy;
	logic hostCopy;
	logic [RULE_COUNT-1:0] ruleBit;
	logic [7:0] queueBit;

	assign hostBit = 55'h1 << HOST_PORT;
	assign ruleBit = RULE_COUNT'(1) << frameIn.ruleIndex;
	assign queueBit = 8'h1 << action.hostQueueSelect;

	// Action takes effect on a hit unless the frame was terminated
	// override termination
	assign applies = frameValid && ruleHit && r.decodeEnable &&
		(!frameIn.terminated || action.overrideTermination);

	// One-shot copy only while this rule has not fired its copy yet
	// single copy arm
	assign armedCopy = action.singleCopyArm && !(|(r.consumed & ruleBit));
	assign hostCopy = action.hostCopyEnable || armedCopy;

	// Optional AND masks for redirect
	// redirect mask ANDs
	assign andTerm = (action.portSet[SRC_AND_BIT] ? frameIn.srcMask : '1) &
		(action.portSet[AGGR_AND_BIT] ? frameIn.aggrMask : '1) &
		(action.portSet[VLAN_AND_BIT] ? frameIn.vlanMask : '1);

	// ************************************************************
	// Destination mask combining
	// ************************************************************
	// modes 0..7
	always_comb begin
		case (action.maskMode)
			MM_OR_DEST: newMask = frameIn.destMask | action.portSet;
			MM_AND_VLAN: newMask = frameIn.destMask &
				(frameIn.vlanMask & action.portSet);
			MM_SUB_PORT_GROUP_INDEX: newMask = action.portSet;
			MM_REPLACE: newMask = action.portSet;
			MM_REDIRECT: newMask = frameIn.redirMask & andTerm;
			MM_OR_PORT_GROUP_INDEX: newMask = frameIn.pgidMask | action.portSet;
			// stacking and no-effect modes keep the mask
			default: newMask = frameIn.destMask;
		endcase
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		rNxt = r;
		rNxt.outValid = frameValid;
		rNxt.hitEvent = 1'b0;
		// Pass-through decision when no action applies
		rNxt.dec = '0;
		rNxt.dec.destMask = frameIn.destMask;
		rNxt.dec.stageCode = frameIn.stageCode;
		rNxt.dec.hostQueues = frameIn.hostQueues;
		rNxt.dec.learnAllow = frameIn.learnAllow;
		rNxt.dec.routeAllow = frameIn.routeAllow;
		rNxt.dec.bucketIndex = frameIn.bucketBase;
		if (applies) begin
			rNxt.dec.actionApplied = 1'b1;
			// whole action word consumed in one format
			// fields taken at their packed positions
			rNxt.dec.innerStage = action.innerAclFlag;
			rNxt.dec.mirrorProbe = action.mirrorProbe;
			if (action.stageForceEnable) begin
				rNxt.dec.stageCode = action.forcedStageCode;
				rNxt.dec.stageActionNone =
					action.forcedStageCode == STAGE_NONE;
			end
			if (action.hostExtractDisable) begin
				rNxt.dec.hostQueues = '0;
			end
			// queue select names the copy queue
			if (hostCopy) begin
				rNxt.dec.hostQueues = rNxt.dec.hostQueues | queueBit;
			end
			if (action.learnBlock) begin
				rNxt.dec.learnAllow = 1'b0;
			end
			if (action.routeBlock) begin
				rNxt.dec.routeAllow = 1'b0;
			end
			rNxt.dec.policerValid = action.policerEnable;
			rNxt.dec.policerIndex = action.policerSelect;
			rNxt.dec.swapValid = !action.policerEnable;
			rNxt.dec.swapIndex = action.policerSelect;
			rNxt.dec.bucketIndex = frameIn.bucketBase +
				BUCKET_W'(action.bucketOffset);
			if (frameIn.aclRouteMode[3:2] == 2'h1 &&
				frameIn.fieldA[8:7] == 2'h3) begin
				rNxt.dec.bucketIndex[2:0] = action.bucketOffset;
			end
			// interval from code and swap enable
			// interval from offset and swap enable
			if (frameIn.rewriteCommand[REWRITE_INTERVAL_BIT] &&
				frameIn.mcDelayResp) begin
				rNxt.dec.intervalValid = 1'b1;
				rNxt.dec.logInterval =
					{frameIn.macSwapEnable, action.intervalCode};
				rNxt.dec.offsetInterval =
					{frameIn.macSwapEnable, action.bucketOffset};
			end
			// host port bit kept from the incoming mask
			rNxt.dec.destMask = (newMask & ~hostBit) |
				(frameIn.destMask & hostBit);
			rNxt.dec.maskLocked = action.maskMode == MM_REPLACE ||
				action.maskMode == MM_REDIRECT ||
				action.maskMode == MM_STACK;
			rNxt.dec.redirValid = action.maskMode == MM_REDIRECT;
			rNxt.dec.redirIndex = action.portSet[REDIR_W-1:0];
			rNxt.dec.stackValid = action.maskMode == MM_STACK;
			rNxt.dec.stackCtrl = action.portSet[STACK_W-1:0];
			rNxt.hitEvent = action.hitInterruptEnable;
			rNxt.hitCount = r.hitCount + 32'h1;
		end

		// APB setup phase: capture read data and error
		if (psel && !penable) begin
			rNxt.slvErr = regDecode(paddr) == 2'h3;
			case (regDecode(paddr))
				2'h0: rNxt.rdata = {31'h0, r.decodeEnable};
				2'h1: rNxt.rdata = 32'(r.consumed);
				2'h2: rNxt.rdata = r.hitCount;
				default: rNxt.rdata = 32'h0;
			endcase
		end

		// APB write at the access edge
		if (psel && penable && pwrite) begin
			case (regDecode(paddr))
				2'h0: rNxt.decodeEnable = pwdata[CTRL_ENABLE_BIT];
				2'h1: rNxt.consumed = r.consumed &
					~pwdata[RULE_COUNT-1:0];
				2'h2: rNxt.hitCount = applies ? 32'h1 : 32'h0;
				default: rNxt.decodeEnable = r.decodeEnable;
			endcase
		end

		// Disarm after the one-shot copy; wins over a rearm write
		// one-shot disarm
		if (applies && armedCopy && !action.hostCopyEnable) begin
			rNxt.consumed = rNxt.consumed | ruleBit;
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			r <= '0;
			r.decodeEnable <= CTRL_ENABLE_RST;
		end else begin
			r <= rNxt;
		end
	end

	// Outputs
	assign pready = 1'b1;
	assign prdata = r.rdata;
	assign pslverr = r.slvErr;
	assign decisionValid = r.outValid;
	assign decision = r.dec;
	assign hitEvent = r.hitEvent;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	hit_event_a: assert property (
		applies && action.hitInterruptEnable |=> hitEvent && decisionValid)
		else $error("interrupt event missing after enabled hit");

	stage_none_a: assert property (
		applies && action.stageForceEnable &&
		action.forcedStageCode == STAGE_NONE
		|=> decision.stageActionNone && decision.stageCode == STAGE_NONE)
		else $error("forced none stage not applied");

	host_port_a: assert property (
		frameValid |=> decision.destMask[HOST_PORT] ==
		$past(frameIn.destMask[HOST_PORT]))
		else $error("host port membership changed");

	one_shot_a: assert property (
		applies && armedCopy && !action.hostCopyEnable
		|=> |(r.consumed & $past(ruleBit)))
		else $error("single copy rule not disarmed");

	extract_cancel_a: assert property (
		applies && action.hostExtractDisable && !hostCopy
		|=> decision.hostQueues == 8'h00)
		else $error("host extraction not cancelled");

	replace_lock_a: assert property (
		applies && action.maskMode == MM_REPLACE |=> decision.maskLocked &&
		(decision.destMask & ~hostBit) == ($past(action.portSet) & ~hostBit))
		else $error("replace mode mask wrong or unlocked");

	interval_rewrite_a: assert property (
		applies && frameIn.rewriteCommand[REWRITE_INTERVAL_BIT] &&
		frameIn.mcDelayResp && frameIn.macSwapEnable
		|=> decision.intervalValid && decision.logInterval[3])
		else $error("negative interval not encoded");

	bucket_bits_a: assert property (
		applies && frameIn.aclRouteMode[3:2] == 2'h1 &&
		frameIn.fieldA[8:7] == 2'h3
		|=> decision.bucketIndex[2:0] == $past(action.bucketOffset))
		else $error("bucket low bits not from offset");

	no_hit_a: assert property (
		frameValid && frameIn.terminated && !action.overrideTermination
		|=> !decision.actionApplied)
		else $error("action applied to terminated frame");

	copy_queue_a: assert property (
		applies && hostCopy
		|=> (decision.hostQueues & $past(queueBit)) != 8'h00)
		else $error("host copy queue bit missing");

	learn_block_a: assert property (
		applies && action.learnBlock |=> !decision.learnAllow)
		else $error("learning not blocked");

	route_block_a: assert property (
		applies && action.routeBlock |=> !decision.routeAllow)
		else $error("routing not blocked");

	policer_swap_a: assert property (
		applies |=> decision.policerValid == !decision.swapValid &&
		decision.swapIndex == $past(action.policerSelect))
		else $error("policer and swap selection disagree");

	redirect_lock_a: assert property (
		applies && action.maskMode == MM_REDIRECT
		|=> decision.maskLocked && decision.redirValid &&
		decision.redirIndex == $past(action.portSet[REDIR_W-1:0]))
		else $error("redirect mode index wrong or unlocked");

	stack_keep_a: assert property (
		applies && action.maskMode == MM_STACK
		|=> decision.maskLocked && decision.stackValid &&
		decision.destMask == $past(frameIn.destMask))
		else $error("stacking mode changed the mask");

	valid_pulse_a: assert property (
		frameValid |=> decisionValid)
		else $error("decision missing after frame");

	idle_quiet_a: assert property (
		!frameValid |=> !decisionValid && !hitEvent)
		else $error("output pulse without a frame");

endmodule

`default_nettype wire

// ===== acl_action_pkg.sv
// Shared widths, action layout, frame carriers and register map
package acl_action_pkg;

	// ************************************************************
	// Action word and field widths
	// ************************************************************
	localparam int ACTION_W = 196;
	localparam int MASK_W = 55;
	localparam int STAGE_W = 5;
	localparam int QUEUE_W = 3;
	localparam int QUEUE_N = 8;
	localparam int POLICER_W = 5;
	localparam int BUCKET_W = 12;
	localparam int RULE_W = 5;
	localparam int REDIR_W = 11;
	localparam int STACK_W = 35;

	// Stage codes at the ends of the range
	localparam logic [4:0] STAGE_NONE = 5'h00;
	localparam logic [4:0] STAGE_DONE = 5'h10;

	// Mask combine modes
	localparam logic [2:0] MM_OR_DEST = 3'h0;
	localparam logic [2:0] MM_AND_VLAN = 3'h1;
	localparam logic [2:0] MM_SUB_PORT_GROUP_INDEX = 3'h2;
	localparam logic [2:0] MM_REPLACE = 3'h3;
	localparam logic [2:0] MM_REDIRECT = 3'h4;
	localparam logic [2:0] MM_OR_PORT_GROUP_INDEX = 3'h5;
	localparam logic [2:0] MM_STACK = 3'h6;

	// Port set bits used by the redirect mode, and the rewrite interval bit
	localparam int SRC_AND_BIT = 52;
	localparam int AGGR_AND_BIT = 51;
	localparam int VLAN_AND_BIT = 50;
	localparam int REWRITE_INTERVAL_BIT = 5;

	// ************************************************************
	// Register map (APB byte addresses) and reset values
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ARM = 8'h04;
	localparam logic [7:0] REG_HITS = 8'h08;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RST = 1'b1;

	// Action word, first field at bit 0 (last member here)
	typedef struct packed {
		logic [106:0] laterFields;
		logic [1:0] mirrorProbe;
		logic [54:0] portSet;
		logic [2:0] maskMode;
		logic [2:0] intervalCode;
		logic [2:0] bucketOffset;
		logic overrideTermination;
		logic [4:0] policerSelect;
		logic policerEnable;
		logic routeBlock;
		logic learnBlock;
		logic hostExtractDisable;
		logic [2:0] hostQueueSelect;
		logic hostCopyEnable;
		logic hitInterruptEnable;
		logic singleCopyArm;
		logic [4:0] forcedStageCode;
		logic stageForceEnable;
		logic innerAclFlag;
	} action_s;

	// Decision arriving from the forwarding pipeline
	typedef struct packed {
		logic [54:0] destMask;
		logic [54:0] vlanMask;
		logic [54:0] pgidMask;
		logic [54:0] srcMask;
		logic [54:0] aggrMask;
		logic [54:0] redirMask;
		logic [4:0] stageCode;
		logic terminated;
		logic [7:0] hostQueues;
		logic learnAllow;
		logic routeAllow;
		logic [11:0] bucketBase;
		logic [5:0] rewriteCommand;
		logic [3:0] aclRouteMode;
		logic [8:0] fieldA;
		logic macSwapEnable;
		logic mcDelayResp;
		logic [4:0] ruleIndex;
	} frame_s;

	// Decision handed on to the pipeline
	typedef struct packed {
		logic [54:0] destMask;
		logic maskLocked;
		logic redirValid;
		logic [10:0] redirIndex;
		logic stackValid;
		logic [34:0] stackCtrl;
		logic [4:0] stageCode;
		logic stageActionNone;
		logic innerStage;
		logic [7:0] hostQueues;
		logic learnAllow;
		logic routeAllow;
		logic policerValid;
		logic [4:0] policerIndex;
		logic swapValid;
		logic [4:0] swapIndex;
		logic [11:0] bucketIndex;
		logic intervalValid;
		logic [3:0] logInterval;
		logic [3:0] offsetInterval;
		logic [1:0] mirrorProbe;
		logic actionApplied;
	} decision_s;

endpackage

// ===== acl_lookup_model.sv
// Lookup engine side model that presents one frame per request
`timescale 1ns/10ps
`default_nettype none
module acl_lookup_model
	import acl_action_pkg::*;
(
	input wire logic mclk,
	input wire logic go,
	input wire logic hitIn,
	input wire action_s actIn,
	input wire frame_s frmIn,
	output logic frameValid,
	output logic ruleHit,
	output action_s action,
	output frame_s frameIn
);
	// action packed from bit 0 upward
	// Drive one frame; between frames frameValid stays low and the other lines invert every cycle
	always_ff @(posedge mclk) begin
		frameValid <= go;
		if (go) begin
			ruleHit <= hitIn;
			action <= actIn;
			frameIn <= frmIn;
		end else begin
			ruleHit <= ~ruleHit;
			action <= ~action;
			frameIn <= ~frameIn;
		end
	end
endmodule
`default_nettype wire

// ===== test_acl_action_decoder.sv
// Self-checking bench for the action decoder
`timescale 1ns/10ps
`default_nettype none
module test_acl_action_decoder;
	import acl_action_pkg::*;
	localparam logic [54:0] DM = {11{5'h15}};
	localparam logic [54:0] VM = {11{5'h0e}};
	localparam logic [54:0] SM = {11{5'h13}};
	localparam logic [54:0] CM = {11{5'h1b}};
	localparam logic [54:0] AM = {11{5'h1d}};
	localparam logic [54:0] RM = {11{5'h17}};
	logic mclk, reset, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic frameValid, ruleHit, decisionValid, hitEvent, go, hit, ev, er;
	action_s act, action;
	frame_s frm, frameIn;
	decision_s decision, dec;
	int bad_count, n_checks, cycles;
	logic [4:0] codes [3] = '{5'h00, 5'h07, 5'h10};

	acl_lookup_model model (.mclk(mclk), .go(go), .hitIn(hit),
		.actIn(act), .frmIn(frm), .frameValid(frameValid),
		.ruleHit(ruleHit), .action(action), .frameIn(frameIn));
	acl_action_decoder dut (.mclk(mclk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frameValid(frameValid), .ruleHit(ruleHit),
		.action(action), .frameIn(frameIn),
		.decisionValid(decisionValid), .decision(decision),
		.hitEvent(hitEvent));

	// ************
	// Clock, timeout
	// ************
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 3000) begin
			bad_count++;
			test_done();
		end
	end

	// ************
	// Tasks
	// ************
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] s, e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	// APB cycle: setup, access held until pready high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic base();
		act = '0;
		act.portSet = SM;
		act.portSet[53] = 1'b1; // Host port bit must never pass
		frm = '0;
		frm.destMask = DM;
		frm.pgidMask = DM;
		frm.vlanMask = VM;
		frm.srcMask = CM;
		frm.aggrMask = AM;
		frm.redirMask = RM;
		hit = 1'b1;
	endtask
	task automatic send();
		@(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (4) begin
			@(negedge mclk);
			if (decisionValid === 1'b1) break;
		end
		chk("valid", decisionValid, 1'b1);
		dec = decision;
		ev = hitEvent;
	endtask
	function automatic logic [54:0] expMask(input int m);
		logic [54:0] r;
		case (m)
			0, 5: r = DM | SM;
			1: r = DM & VM & SM;
			2, 3: r = SM;
			4: r = RM & (SM[52] ? CM : '1) & (SM[51] ? AM : '1)
				& (SM[50] ? VM : '1);
			default: r = DM;
		endcase
		r[53] = DM[53];
		return r;
	endfunction

	// ************
	// Tests
	// ************
	initial begin
		{reset, psel, penable, pwrite, go, hit} = 6'h21;
		paddr = 8'h00;
		pwdata = 32'h0;
		act = '0;
		frm = '0;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", rd, 32'h1);
		apb(1'b0, REG_ARM, 32'h0);
		chk("arm", rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("err", er, 1'b1);
		// Action width and field placement
		chk("width", $bits(action_s), 196);
		act = action_s'((196'h1 << 29) | (196'h1 << 87));
		chk("layout", {act.mirrorProbe, act.maskMode}, 5'h09);
		for (int m = 0; m < 8; m++) begin
			base();
			act.maskMode = m[2:0];
			act.mirrorProbe = m[1:0];
			send();
			chk("dest", dec.destMask, expMask(m));
			chk("lock", dec.maskLocked, m inside {3, 4, 6});
			chk("redirv", dec.redirValid, m == 4);
			chk("stackv", dec.stackValid, m == 6);
			chk("mirror", dec.mirrorProbe, m[1:0]);
			chk("ival0", dec.intervalValid, 1'b0);
			if (m == 4) chk("redir", dec.redirIndex, SM[10:0]);
			if (m == 6) chk("stack", dec.stackCtrl, SM[34:0]);
		end
		for (int i = 0; i < 4; i++) begin
			base();
			act.stageForceEnable = (i < 3);
			act.forcedStageCode = (i < 3) ? codes[i] : 5'h09;
			act.innerAclFlag = i[0];
			frm.stageCode = 5'h03;
			send();
			chk("stage", dec.stageCode, act.forcedStageCode * (i < 3) + 3 * (i == 3));
			chk("none", dec.stageActionNone, i == 0);
			chk("inner", dec.innerStage, i[0]);
		end
		for (int q = 0; q < 9; q++) begin
			base();
			frm.hostQueues = (q < 8) ? 8'hff : 8'h03;
			act.hostExtractDisable = (q < 8);
			act.hostCopyEnable = 1'b1;
			act.hostQueueSelect = (q < 8) ? q[2:0] : 3'h5;
			send();
			chk("queue", dec.hostQueues, (q < 8) ? 8'h01 << q : 8'h23);
		end
		// One-shot copies, then copy enable overruling the one-shot
		for (int k = 0; k < 5; k++) begin
			base();
			act.singleCopyArm = 1'b1;
			act.hostCopyEnable = (k > 2);
			act.hostQueueSelect = 3'h2;
			frm.ruleIndex = 5'h09;
			send();
			chk("once", dec.hostQueues, (k == 1) ? 8'h00 : 8'h04);
			if (k == 1 || k == 2) begin
				apb(1'b0, REG_ARM, 32'h0);
				chk("armed", rd, 32'h200);
				apb(1'b1, REG_ARM, 32'h200);
			end
		end
		apb(1'b0, REG_ARM, 32'h0);
		chk("copyall", rd, 32'h0);
		for (int j = 0; j < 2; j++) begin
			base();
			act.learnBlock = !j;
			act.routeBlock = !j;
			act.policerEnable = !j;
			act.policerSelect = 5'h17;
			act.bucketOffset = 3'h5;
			act.intervalCode = j ? 3'h7 : 3'h3;
			act.hitInterruptEnable = !j;
			frm.learnAllow = 1'b1;
			frm.routeAllow = 1'b1;
			frm.bucketBase = 12'h0f9;
			frm.rewriteCommand = 6'h20;
			frm.mcDelayResp = 1'b1;
			frm.macSwapEnable = !j;
			frm.aclRouteMode = j ? 4'h4 : 4'h0;
			frm.fieldA = j ? 9'h180 : 9'h000;
			send();
			chk("learn", dec.learnAllow, j);
			chk("route", dec.routeAllow, j);
			chk("police", {dec.policerValid, dec.policerIndex}, {!j, 5'h17});
			chk("swap", {dec.swapValid, dec.swapIndex}, {j, 5'h17});
			chk("bucket", dec.bucketIndex, j ? 12'h0fd : 12'h0fe);
			chk("ival", dec.intervalValid, 1'b1);
			chk("log", dec.logInterval, j ? 4'h7 : 4'hb);
			chk("offs", dec.offsetInterval, j ? 4'h5 : 4'hd);
			chk("event", ev, !j);
		end
		for (int t = 0; t < 4; t++) begin
			base();
			frm.terminated = (t < 2);
			act.overrideTermination = (t == 1);
			act.maskMode = 3'h3;
			hit = (t != 2);
			if (t == 3) apb(1'b1, REG_CTRL, 32'h0);
			send();
			chk("applied", dec.actionApplied, t == 1);
			chk("pass", dec.destMask, (t == 1) ? expMask(3) : DM);
		end
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_HITS, 32'h0);
		base();
		send();
		apb(1'b0, REG_HITS, 32'h0);
		chk("hits", rd, 32'h1);
		test_done();
	end
endmodule
`default_nettype wire
